// file: core/rls_consts.svh
// Offsets, field positions, codes and timing for the shortcut block
`ifndef RLS_CONSTS_SVH
`define RLS_CONSTS_SVH
// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_OUT_ASSIGN 8'h08
`define OFF_PRM_SEL 8'h0c
`define OFF_PRM_DATA 8'h10
`define OFF_TABLE 8'h40
// Control register bits
`define CTRL_EDIT 0
`define CTRL_TAKE 1
`define CTRL_NEWLINE 2
`define CTRL_HOSTLINK 3
`define CTRL_DEFAULTS 4
`define CTRL_TALLY_LO 5
`define CTRL_TALLY_HI 6
`define CTRL_RESET 7'h00
// Tally polarity codes
`define TALLY_UNDEF 2'h0
`define TALLY_HIGH 2'h1
`define TALLY_LOW 2'h2
// Accessory output assign codes, 3 bits per contact
`define OA_UNDEF 3'h0
`define OA_BITS 3
// Front-panel button mask bits
`define BTN_STOP 8'h01
`define BTN_PLAY 8'h02
`define BTN_REC 8'h04
`define BTN_TOGGLE_OK 8'h06
// Modifier one-hot codes {alt, ctrl, shift}
`define MOD_NONE 3'h0
`define MOD_SHIFT 3'h1
`define MOD_CTRL 3'h2
`define MOD_ALT 3'h4
// Key codes
`define KEY_F1 8'hf1
`define KEY_F12 8'hfc
`define KEY_D0 8'h30
`define KEY_D9 8'h39
`define KEY_A 8'h41
`define KEY_Z 8'h5a
`define KEY_PRINT_LO 8'h20
`define KEY_PRINT_HI 8'h7e
`define KEY_SPACE 8'h20
`define KEY_BKSP 8'h08
`define KEY_ENTER 8'h0d
`define KEY_ESC 8'h1b
`define KEY_DEL 8'h7f
`define KEY_INS 8'h90
`define KEY_UP 8'h91
`define KEY_DOWN 8'h92
`define KEY_LEFT 8'h93
`define KEY_RIGHT 8'h94
`define KEY_HOME 8'h95
`define KEY_END 8'h96
`define KEY_LOGIC_IN 8'h80
// Debounce time and clock rate
`define DEBOUNCE_US 5000
`define CLK_MHZ 25
`endif

// file: core/rls_pkg.sv
// Types shared by the shortcut block and its bench
package rls_pkg;
  typedef enum logic [2:0] {
    ACT_MOMENTARY = 3'b000, ACT_TOGGLE = 3'b001, ACT_OPEN_MENU = 3'b010,
    ACT_CYCLE = 3'b011, ACT_SET = 3'b100, ACT_TC_OPEN = 3'b101,
    ACT_TC_JAM = 3'b110, ACT_KEY_COMBO = 3'b111
  } action_e;
  typedef enum logic [1:0] {
    REC_STOP = 2'b00, REC_PLAY = 2'b01, REC_RECORD = 2'b10,
    REC_PAUSE = 2'b11
  } rec_state_e;
  typedef enum logic [3:0] {
    ED_NONE = 4'b0000, ED_INSERT = 4'b0001, ED_BACKSPACE = 4'b0010,
    ED_DELETE = 4'b0011, ED_RESET = 4'b0100, ED_NEWLINE = 4'b0101,
    ED_SAVE = 4'b0110, ED_CANCEL = 4'b0111, ED_INC = 4'b1000,
    ED_DEC = 4'b1001, ED_LEFT = 4'b1010, ED_RIGHT = 4'b1011,
    ED_HOME = 4'b1100, ED_END = 4'b1101
  } edit_op_e;
  typedef struct packed {
    logic press;
    logic [2:0] mods;
    logic [7:0] key;
  } kb_event_s;
  typedef struct packed {
    logic [7:0] value;
    logic [7:0] target;
    action_e action;
    logic [7:0] key;
    logic [2:0] mods;
    logic en;
  } sc_entry_s;
  typedef struct packed {
    action_e action;
    logic [7:0] target;
    logic [7:0] value;
  } act_s;
  typedef struct packed {
    logic [3:0] idx;
    logic [7:0] value;
  } persist_s;
  typedef struct packed {
    edit_op_e op;
    logic [7:0] ch;
  } edit_s;
endpackage : rls_pkg

// file: core/remote_logic_shortcut_io.sv
// Shortcut table, logic input, record tally and accessory contacts
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ns
`include "rls_consts.svh"

// Behaviour
// - Duplicate key in several entries: only the lowest-numbered entry acts.
// - F-keys alone or with one modifier; digits, letters only with Ctrl/Alt.
// - Toggle action flips its key state; allowed only for play and record.
// - Momentary action mimics the front-panel button in any screen.
// - Cycle action steps a setup parameter to its next value and saves.
// - Set action loads the entry's fixed value into a parameter and saves.
// - Key-combo action presses several front-panel buttons at once.
// - Rear logic input pulled low triggers its assigned function.
// - After configuration reset the rear logic input records.
// - Tally high or low while recording by polarity; undefined when unset.
// - Six accessory contacts, each assignable to actions or transport.
// - Each contact independently works as input or as output.
// - Contacts active low: grounded input is on; output 0 on, 1 off.
// - Input contact N acts as an extra key in the shortcut table.
// - Output contact shows stop, play, record, pause, or is unassigned.
// - A contact assigned both ways acts only as an output.
// - Host-software link mode disables the accessory port.
// - Editing: printable chars insert; take field digits insert, letters space.
// - Backspace deletes before cursor; delete removes char or resets take.
// - Enter inserts line break if allowed, else saves; Ctrl+Enter saves.
// - Up/down step the character, left/right move the cursor.
// - Escape cancels; home and end jump to string ends.
module remote_logic_shortcut_io #(
  parameter int NSC = 8,
  parameter int NPARAM = 16,
  parameter int NCONTACT = 6,
  parameter int DEB_CYC = `DEBOUNCE_US * `CLK_MHZ
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  // Keyboard events
  input wire logic kb_valid_i,
  input wire rls_pkg::kb_event_s kb_i,
  // Rear logic input and tally
  input wire logic logic_in_n_i,
  output logic tally_o,
  // Accessory contacts
  input wire logic [NCONTACT-1:0] contact_n_i,
  output logic [NCONTACT-1:0] contact_n_o,
  output logic [NCONTACT-1:0] contact_oe_o,
  // Recorder state
  input wire rls_pkg::rec_state_e rec_state_i,
  // Actions toward the recorder
  output logic [7:0] buttons_o,
  output logic act_valid_o,
  output rls_pkg::act_s act_o,
  output logic persist_valid_o,
  output rls_pkg::persist_s persist_o,
  output logic edit_valid_o,
  output rls_pkg::edit_s edit_o
);
  localparam int NSRC = NCONTACT + 1;
  localparam int CW = $clog2(DEB_CYC + 1);
  localparam logic [CW-1:0] DEB_LAST = CW'(DEB_CYC - 1);

  // Byte-lane merge for bus writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction : merge

  // Legal key and modifier pairs
  function automatic logic key_ok(input logic [2:0] m, input logic [7:0] k);
    logic fk, dl, one;
    fk = (k >= `KEY_F1) && (k <= `KEY_F12);
    dl = ((k >= `KEY_D0) && (k <= `KEY_D9)) ||
         ((k >= `KEY_A) && (k <= `KEY_Z));
    one = (m == `MOD_NONE) || (m == `MOD_SHIFT) || (m == `MOD_CTRL) ||
          (m == `MOD_ALT);
    if (fk) return one;
    if (dl) return (m == `MOD_CTRL) || (m == `MOD_ALT);
    return (m == `MOD_NONE) && (k >= `KEY_LOGIC_IN) &&
           (k < `KEY_LOGIC_IN + 8'(NSRC));
  endfunction : key_ok

  // Factory table: entry 0 maps the rear input to record
  function automatic rls_pkg::sc_entry_s dflt(input int i);
    rls_pkg::sc_entry_s e;
    e = '0;
    if (i == 0) begin
      e.en = 1'b1;
      e.key = `KEY_LOGIC_IN;
      e.action = rls_pkg::ACT_MOMENTARY;
      e.target = `BTN_REC;
    end
    return e;
  endfunction : dflt

  logic [6:0] ctrl_r;
  logic [31:0] oa_r;
  logic [3:0] psel_r;
  rls_pkg::sc_entry_s tab_r [NSC];
  logic [7:0] prm_r [NPARAM];
  logic [7:0] lim_r [NPARAM];
  logic [NSRC-1:0] s1_r, s2_r, stable_r, pend_p_r, pend_r_r;
  logic [CW-1:0] cnt_r [NSRC];
  logic [7:0] hold_r, tog_r;
  logic bus_go, wr_go, defaults;
  logic [NSRC-1:0] src_ok, fall, rise, served;
  logic ev_valid, ev_press, hit;
  logic [2:0] ev_mods;
  logic [7:0] ev_key;
  rls_pkg::sc_entry_s ent;
  logic [7:0] pval;

  assign bus_go = cyc_i && stb_i && !ack_o;
  assign wr_go = bus_go && we_i;
  assign defaults = wr_go && (adr_i == `OFF_CTRL) && sel_i[0] &&
                    dat_i[`CTRL_DEFAULTS];

  // Bus handshake: ack one cycle after the strobe, dropped next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) ack_o <= 1'b0;
    else ack_o <= bus_go;
  end

  // Control, output assignment and parameter select registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `CTRL_RESET;
      oa_r <= '0;
      psel_r <= '0;
    end else if (wr_go) begin
      case (adr_i)
        `OFF_CTRL: ctrl_r <= 7'(merge(32'(ctrl_r), dat_i, sel_i)) &
                             ~(7'h1 << `CTRL_DEFAULTS);
        `OFF_OUT_ASSIGN: oa_r <= merge(oa_r, dat_i, sel_i);
        `OFF_PRM_SEL: psel_r <= 4'(merge(32'(psel_r), dat_i, sel_i));
        default: ;
      endcase
    end
  end

  // Shortcut table; the defaults strobe reloads factory entries
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NSC; i++) begin
      if (rst_i || defaults) tab_r[i] <= dflt(i);
      else if (wr_go && (adr_i == `OFF_TABLE + 8'(4 * i)))
        tab_r[i] <= 31'(merge(32'(tab_r[i]), dat_i, sel_i));
    end
  end

  // Read mux; unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) dat_o <= '0;
    else if (bus_go && !we_i) begin
      dat_o <= '0;
      case (adr_i)
        `OFF_CTRL: dat_o <= 32'(ctrl_r);
        `OFF_STATUS: dat_o <= {6'h00, rec_state_i, tog_r, hold_r, 1'b0,
                               stable_r};
        `OFF_OUT_ASSIGN: dat_o <= oa_r;
        `OFF_PRM_SEL: dat_o <= 32'(psel_r);
        `OFF_PRM_DATA: dat_o <= {16'h0000, lim_r[psel_r], prm_r[psel_r]};
        default: begin
          for (int i = 0; i < NSC; i++) begin
            if (adr_i == `OFF_TABLE + 8'(4 * i)) dat_o <= 32'(tab_r[i]);
          end
        end
      endcase
    end
  end

  // Two-stage synchroniser, idle high since inputs are active low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '1;
      s2_r <= '1;
    end else begin
      s1_r <= {contact_n_i, logic_in_n_i};
      s2_r <= s1_r;
    end
  end

  // Debounce: level must hold for the full window before it counts
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NSRC; i++) begin
      if (rst_i) begin
        stable_r[i] <= 1'b1;
        cnt_r[i] <= '0;
      end else if (s2_r[i] == stable_r[i]) cnt_r[i] <= '0;
      else if (cnt_r[i] == DEB_LAST) begin
        stable_r[i] <= s2_r[i];
        cnt_r[i] <= '0;
      end else cnt_r[i] <= cnt_r[i] + 1'b1;
    end
  end

  // Edge detection and which sources may feed the table
  always_comb begin
    src_ok[0] = 1'b1;
    for (int i = 1; i < NSRC; i++) begin
      src_ok[i] = !ctrl_r[`CTRL_HOSTLINK] &&
                  (oa_r[(i-1)*`OA_BITS +: `OA_BITS] == `OA_UNDEF);
    end
    for (int i = 0; i < NSRC; i++) begin
      fall[i] = 1'b0;
      rise[i] = 1'b0;
      if (s2_r[i] != stable_r[i] && cnt_r[i] == DEB_LAST) begin
        fall[i] = !s2_r[i];
        rise[i] = s2_r[i];
      end
    end
  end

  // Event pick: keyboard first, then lowest pending source, rear input before contacts
  always_comb begin
    ev_valid = 1'b0;
    ev_press = 1'b0;
    ev_mods = `MOD_NONE;
    ev_key = 8'h00;
    served = '0;
    if (kb_valid_i && !ctrl_r[`CTRL_EDIT]) begin
      ev_valid = 1'b1;
      ev_press = kb_i.press;
      ev_mods = kb_i.mods;
      ev_key = kb_i.key;
    end else begin
      for (int i = NSRC - 1; i >= 0; i--) begin
        if (pend_p_r[i] || pend_r_r[i]) begin
          served = '0;
          served[i] = 1'b1;
        end
      end
      for (int i = 0; i < NSRC; i++) begin
        if (served[i]) begin
          ev_valid = 1'b1;
          ev_press = pend_p_r[i];
          ev_key = `KEY_LOGIC_IN + 8'(i);
        end
      end
    end
  end

  // Pending edges; a new edge beats the clear of the one being served
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_p_r <= '0;
      pend_r_r <= '0;
    end else begin
      pend_p_r <= ((pend_p_r & ~served) | fall) & src_ok;
      pend_r_r <= ((pend_r_r & ~(served & ~pend_p_r)) | rise) & src_ok;
    end
  end

  // Lowest matching entry wins, scanned from the top down
  always_comb begin
    hit = 1'b0;
    ent = '0;
    for (int i = NSC - 1; i >= 0; i--) begin
      if (ev_valid && tab_r[i].en && tab_r[i].key == ev_key &&
          tab_r[i].mods == ev_mods && key_ok(ev_mods, ev_key)) begin
        hit = 1'b1;
        ent = tab_r[i];
      end
    end
    pval = (prm_r[ent.target[3:0]] >= lim_r[ent.target[3:0]]) ? 8'h00 :
           prm_r[ent.target[3:0]] + 8'h01;
  end

  // Held and toggled front-panel buttons
  always_ff @(posedge clk_i) begin
    if (rst_i || defaults) begin
      hold_r <= '0;
      tog_r <= '0;
    end else if (hit) begin
      case (ent.action)
        rls_pkg::ACT_MOMENTARY, rls_pkg::ACT_KEY_COMBO: begin
          if (ev_press) hold_r <= hold_r | ent.target;
          else hold_r <= hold_r & ~ent.target;
        end
        rls_pkg::ACT_TOGGLE: begin
          if (ev_press) tog_r <= tog_r ^ (ent.target & `BTN_TOGGLE_OK);
        end
        default: ;
      endcase
    end
  end

  // Outputs mirror held and toggled buttons; no menu dependence
  always_ff @(posedge clk_i) begin
    if (rst_i) buttons_o <= '0;
    else buttons_o <= hold_r | tog_r;
  end

  // Setup parameter store, cycled, set, or written over the bus
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NPARAM; i++) begin
      if (rst_i) begin
        prm_r[i] <= '0;
        lim_r[i] <= '0;
      end else if (hit && ev_press && ent.target[3:0] == 4'(i) &&
                   ent.action == rls_pkg::ACT_CYCLE)
        prm_r[i] <= pval;
      else if (hit && ev_press && ent.target[3:0] == 4'(i) &&
               ent.action == rls_pkg::ACT_SET)
        prm_r[i] <= ent.value;
      else if (wr_go && adr_i == `OFF_PRM_DATA && psel_r == 4'(i)) begin
        if (sel_i[0]) prm_r[i] <= dat_i[7:0];
        if (sel_i[1]) lim_r[i] <= dat_i[15:8];
      end
    end
  end

  // Save pulse after a cycle or set, carrying the stored value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      persist_valid_o <= 1'b0;
      persist_o <= '0;
    end else begin
      persist_valid_o <= hit && ev_press &&
                         (ent.action == rls_pkg::ACT_CYCLE ||
                          ent.action == rls_pkg::ACT_SET);
      persist_o.idx <= ent.target[3:0];
      persist_o.value <= (ent.action == rls_pkg::ACT_CYCLE) ? pval :
                         ent.value;
    end
  end

  // Every matched press is also reported for menu-side actions
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_valid_o <= 1'b0;
      act_o <= '0;
    end else begin
      act_valid_o <= hit && ev_press;
      act_o <= {ent.action, ent.target, ent.value};
    end
  end

  // String editor keys, only while editing is on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edit_valid_o <= 1'b0;
      edit_o <= '0;
    end else begin
      edit_valid_o <= kb_valid_i && kb_i.press && ctrl_r[`CTRL_EDIT];
      edit_o.ch <= kb_i.key;
      case (kb_i.key)
        `KEY_BKSP: edit_o.op <= rls_pkg::ED_BACKSPACE;
        `KEY_DEL: edit_o.op <= ctrl_r[`CTRL_TAKE] ? rls_pkg::ED_RESET :
                               rls_pkg::ED_DELETE;
        `KEY_ENTER: begin
          if (kb_i.mods == `MOD_CTRL || !ctrl_r[`CTRL_NEWLINE])
            edit_o.op <= rls_pkg::ED_SAVE;
          else edit_o.op <= rls_pkg::ED_NEWLINE;
        end
        `KEY_INS: begin
          edit_o.op <= rls_pkg::ED_INSERT;
          edit_o.ch <= `KEY_SPACE;
        end
        `KEY_ESC: edit_o.op <= rls_pkg::ED_CANCEL;
        `KEY_UP: edit_o.op <= rls_pkg::ED_INC;
        `KEY_DOWN: edit_o.op <= rls_pkg::ED_DEC;
        `KEY_LEFT: edit_o.op <= rls_pkg::ED_LEFT;
        `KEY_RIGHT: edit_o.op <= rls_pkg::ED_RIGHT;
        `KEY_HOME: edit_o.op <= rls_pkg::ED_HOME;
        `KEY_END: edit_o.op <= rls_pkg::ED_END;
        default: begin
          edit_o.op <= rls_pkg::ED_NONE;
          if (kb_i.key >= `KEY_PRINT_LO && kb_i.key <= `KEY_PRINT_HI) begin
            if (!ctrl_r[`CTRL_TAKE]) edit_o.op <= rls_pkg::ED_INSERT;
            else if (kb_i.key >= `KEY_D0 && kb_i.key <= `KEY_D9)
              edit_o.op <= rls_pkg::ED_INSERT;
            else if (kb_i.key >= `KEY_A && kb_i.key <= `KEY_Z) begin
              edit_o.op <= rls_pkg::ED_INSERT;
              edit_o.ch <= `KEY_SPACE;
            end
          end
        end
      endcase
    end
  end

  // Contact drivers: on pulls low, off drives high, inputs float
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NCONTACT; i++) begin
      if (rst_i) begin
        contact_n_o[i] <= 1'b1;
        contact_oe_o[i] <= 1'b0;
      end else begin
        contact_oe_o[i] <= !ctrl_r[`CTRL_HOSTLINK] &&
                           oa_r[i*`OA_BITS +: `OA_BITS] != `OA_UNDEF;
        contact_n_o[i] <= oa_r[i*`OA_BITS +: `OA_BITS] !=
                          {1'b0, rec_state_i} + 3'h1;
      end
    end
  end

  // Tally; unassigned polarity is held low by choice
  always_ff @(posedge clk_i) begin
    if (rst_i) tally_o <= 1'b0;
    else begin
      case (ctrl_r[`CTRL_TALLY_HI:`CTRL_TALLY_LO])
        `TALLY_HIGH: tally_o <= rec_state_i == rls_pkg::REC_RECORD;
        `TALLY_LOW: tally_o <= rec_state_i != rls_pkg::REC_RECORD;
        default: tally_o <= 1'b0;
      endcase
    end
  end
endmodule : remote_logic_shortcut_io

// file: testbench/rls_checker_props.sv
// Checker of bus answers and action outputs of the shortcut block
`timescale 1ns/1ns
`include "rls_consts.svh"
module rls_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  // Key path
  input wire logic kb_valid_i,
  input wire logic [7:0] buttons_o,
  input wire logic act_valid_o,
  input wire rls_pkg::act_s act_o,
  input wire logic persist_valid_o,
  input wire logic edit_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request with no answer pending
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  // Matched press that holds front-panel buttons
  sequence s_btn_press;
    act_valid_o && (act_o.action == rls_pkg::ACT_MOMENTARY ||
      act_o.action == rls_pkg::ACT_KEY_COMBO);
  endsequence
  a_ack_next_cycle: assert property (s_req |=> ack_o)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  // Reset clears read data, so skip the edge right after release
  a_dat_read_only: assert property ($changed(dat_o) && !$past(rst_i)
    |-> ack_o && !we_i)
    else $error("read data moved outside a read answer");
  a_persist_on_save: assert property (persist_valid_o |-> act_valid_o &&
    act_o.action inside {rls_pkg::ACT_CYCLE, rls_pkg::ACT_SET})
    else $error("saved value without cycle or set action");
  a_btn_held_next: assert property (s_btn_press |=>
    (buttons_o & $past(act_o.target)) == $past(act_o.target))
    else $error("buttons not pressed after action");
  a_toggle_play_rec: assert property (act_valid_o &&
    act_o.action == rls_pkg::ACT_TOGGLE |=>
    ((buttons_o ^ $past(buttons_o)) & ~`BTN_TOGGLE_OK) == 8'h00)
    else $error("toggle on a key other than play or record");
  a_edit_from_key: assert property (edit_valid_o |-> $past(kb_valid_i))
    else $error("edit operation without key event");
endmodule : rls_checker

bind remote_logic_shortcut_io rls_checker i_chk (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o),
  .dat_o(dat_o), .kb_valid_i(kb_valid_i), .buttons_o(buttons_o),
  .act_valid_o(act_valid_o), .act_o(act_o),
  .persist_valid_o(persist_valid_o), .edit_valid_o(edit_valid_o));

// file: testbench/rls_switch_panel.sv
// Mixer output and switch closures facing the shortcut block
`timescale 1ns/1ns
module rls_switch_panel #(
  parameter int NCONTACT = 6
) (
  // Closures, bit 0 rear input, bit n+1 contact n
  input wire logic [NCONTACT:0] close_i,
  // Device drive of the contacts
  input wire logic [NCONTACT-1:0] dev_n_i,
  input wire logic [NCONTACT-1:0] dev_oe_i,
  // Resolved lines
  output logic logic_in_n_o,
  output logic [NCONTACT-1:0] line_n_o
);
  // Mixer pulls low to request, pull-up otherwise
  assign logic_in_n_o = !close_i[0];
  // Pull-up to +5 V; closure grounds it; never closed on a driven output
  always_comb begin
    for (int i = 0; i < NCONTACT; i++) begin
      line_n_o[i] = dev_oe_i[i] ? dev_n_i[i] : !close_i[i+1];
    end
  end
endmodule : rls_switch_panel

// file: testbench/remote_logic_shortcut_io_test.sv
// Self-checking bench for the shortcut block
`timescale 1ns/1ns
`include "rls_consts.svh"
module remote_logic_shortcut_io_test;
  logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, kb_valid_i, tally_o;
  logic logic_in_n_i, act_valid_o, persist_valid_o, edit_valid_o;
  logic av, pv, ev;
  logic [7:0] adr_i, buttons_o;
  logic [31:0] dat_i, dat_o, rd;
  logic [3:0] sel_i;
  logic [5:0] contact_n_i, contact_n_o, contact_oe_o;
  logic [6:0] close;
  rls_pkg::kb_event_s kb_i;
  rls_pkg::rec_state_e rec_state_i;
  rls_pkg::act_s act_o;
  rls_pkg::persist_s persist_o;
  rls_pkg::edit_s edit_o;
  int error_cnt, checked;
  // Edit cases: ctrl, mods, key, expected op
  logic [23:0] et [16] = '{24'h010611, 24'h030371, 24'h030511,
    24'h0307f4, 24'h0107f3, 24'h010082, 24'h0101b7, 24'h010918,
    24'h010929, 24'h01093a, 24'h01094b, 24'h01095c, 24'h01096d,
    24'h0500d5, 24'h0100d6, 24'h010901};

  remote_logic_shortcut_io #(.DEB_CYC(4)) i_dut (.clk_i(clk_i),
    .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .kb_valid_i(kb_valid_i), .kb_i(kb_i),
    .logic_in_n_i(logic_in_n_i), .tally_o(tally_o),
    .contact_n_i(contact_n_i), .contact_n_o(contact_n_o),
    .contact_oe_o(contact_oe_o), .rec_state_i(rec_state_i),
    .buttons_o(buttons_o), .act_valid_o(act_valid_o), .act_o(act_o),
    .persist_valid_o(persist_valid_o), .persist_o(persist_o),
    .edit_valid_o(edit_valid_o), .edit_o(edit_o));

  rls_switch_panel i_panel (.close_i(close), .dev_n_i(contact_n_o),
    .dev_oe_i(contact_oe_o), .logic_in_n_o(logic_in_n_i),
    .line_n_o(contact_n_i));

  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk

  // One classic cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    chk("ack", ack_o, 1'b1);
    if (ack_o !== 1'b1) report_and_stop();
  endtask : wb

  // Key event; pulses captured the cycle after it is taken
  task automatic key(input logic [2:0] m, input logic [7:0] k,
      input logic p);
    @(posedge clk_i);
    kb_valid_i <= 1'b1;
    kb_i <= {p, m, k};
    @(posedge clk_i);
    kb_valid_i <= 1'b0;
    #1;
    av = act_valid_o;
    pv = persist_valid_o;
    ev = edit_valid_o;
  endtask : key

  // Debounce makes contact latency loose, so wait under a bound
  task automatic wait_btn(input logic [7:0] e);
    repeat (60) if (buttons_o !== e) @(posedge clk_i);
    #1;
    chk("buttons", buttons_o, e);
    if (buttons_o !== e) report_and_stop();
  endtask : wait_btn

  function automatic logic [31:0] ent(input logic [2:0] m,
      input logic [7:0] k, input rls_pkg::action_e a,
      input logic [7:0] t, v);
    return {1'b0, v, t, a, k, m, 1'b1};
  endfunction : ent

  initial begin
    error_cnt = 0;
    checked = 0;
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, kb_valid_i} = 4'h0;
    adr_i = 8'h00;
    dat_i = 32'h0;
    sel_i = 4'h0;
    kb_i = '0;
    close = 7'h00;
    rec_state_i = rls_pkg::REC_STOP;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // Defaults, unmapped read, rear input
    wb(1'b0, `OFF_TABLE, 32'h0);
    chk("entry0", rd, 32'h00020801);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", rd, 32'h0);
    @(posedge clk_i);
    close <= 7'h01;
    wait_btn(`BTN_REC);
    @(posedge clk_i);
    close <= 7'h00;
    wait_btn(8'h00);
    wb(1'b0, `OFF_STATUS, 32'h0);
    chk("status", rd, 32'h0000007f);
    $display("reset test done");
    // Shortcut table
    wb(1'b1, 8'h44, ent(`MOD_NONE, `KEY_F1, rls_pkg::ACT_MOMENTARY,
      `BTN_PLAY, 8'h00));
    wb(1'b1, 8'h48, ent(`MOD_NONE, `KEY_F1, rls_pkg::ACT_MOMENTARY,
      `BTN_STOP, 8'h00));
    wb(1'b1, 8'h4c, ent(`MOD_NONE, `KEY_A, rls_pkg::ACT_KEY_COMBO,
      8'h03, 8'h00));
    wb(1'b1, 8'h50, ent(`MOD_NONE, 8'h82, rls_pkg::ACT_MOMENTARY,
      `BTN_STOP, 8'h00));
    wb(1'b1, 8'h54, ent(`MOD_NONE, 8'hf2, rls_pkg::ACT_TOGGLE,
      8'h03, 8'h00));
    wb(1'b1, 8'h58, ent(`MOD_NONE, 8'hf3, rls_pkg::ACT_CYCLE,
      8'h02, 8'h00));
    wb(1'b1, 8'h5c, ent(`MOD_NONE, 8'hf4, rls_pkg::ACT_SET,
      8'h02, 8'h05));
    key(`MOD_NONE, `KEY_F1, 1'b1);
    chk("dup_target", act_o.target, `BTN_PLAY);
    wait_btn(`BTN_PLAY);
    key(`MOD_NONE, `KEY_F1, 1'b0);
    wait_btn(8'h00);
    key(`MOD_NONE, `KEY_A, 1'b1);
    chk("bare_letter", av, 1'b0);
    key(`MOD_NONE, `KEY_A, 1'b0);
    wb(1'b1, 8'h4c, ent(`MOD_CTRL, `KEY_A, rls_pkg::ACT_KEY_COMBO,
      8'h03, 8'h00));
    key(`MOD_CTRL, `KEY_A, 1'b1);
    chk("ctrl_letter", av, 1'b1);
    wait_btn(8'h03);
    key(`MOD_CTRL, `KEY_A, 1'b0);
    wait_btn(8'h00);
    for (int i = 0; i < 2; i++) begin
      key(`MOD_NONE, 8'hf2, 1'b1);
      key(`MOD_NONE, 8'hf2, 1'b0);
      wait_btn(i == 0 ? `BTN_PLAY : 8'h00);
    end
    wb(1'b1, `OFF_PRM_SEL, 32'h2);
    wb(1'b1, `OFF_PRM_DATA, 32'h0101);
    key(`MOD_NONE, 8'hf3, 1'b1);
    chk("cycle", {pv, persist_o}, 13'h1200);
    key(`MOD_NONE, 8'hf3, 1'b0);
    key(`MOD_NONE, 8'hf4, 1'b1);
    chk("set", {pv, persist_o}, 13'h1205);
    key(`MOD_NONE, 8'hf4, 1'b0);
    wb(1'b0, `OFF_PRM_DATA, 32'h0);
    chk("param", rd[15:0], 16'h0105);
    @(posedge clk_i);
    close <= 7'h04;
    wait_btn(`BTN_STOP);
    @(posedge clk_i);
    close <= 7'h00;
    wait_btn(8'h00);
    $display("table test done");
    // Tally and output contacts
    @(posedge clk_i);
    rec_state_i <= rls_pkg::REC_RECORD;
    wb(1'b1, `OFF_OUT_ASSIGN, 32'h3);
    wb(1'b1, `OFF_CTRL, 32'h20);
    repeat (3) @(posedge clk_i);
    chk("tally_hi", tally_o, 1'b1);
    chk("out_en", contact_oe_o, 6'h01);
    chk("out_on", contact_n_i[0], 1'b0);
    wb(1'b1, `OFF_CTRL, 32'h40);
    repeat (3) @(posedge clk_i);
    chk("tally_lo", tally_o, 1'b0);
    wb(1'b1, `OFF_CTRL, 32'h08);
    repeat (3) @(posedge clk_i);
    chk("host_link", contact_oe_o, 6'h00);
    rec_state_i <= rls_pkg::REC_STOP;
    wb(1'b1, `OFF_CTRL, 32'h0);
    repeat (3) @(posedge clk_i);
    chk("out_off", contact_n_i[0], 1'b1);
    $display("output test done");
    // String editing
    foreach (et[i]) begin
      wb(1'b1, `OFF_CTRL, {24'h0, et[i][23:16]});
      key(et[i][14:12], et[i][11:4], 1'b1);
      chk("edit_pulse", ev, 1'b1);
      chk("edit_op", edit_o.op, et[i][3:0]);
      if (et[i][3:0] == 4'h1) begin
        chk("edit_ch", edit_o.ch, ((et[i][17] && et[i][11:4] >= `KEY_A) ||
          et[i][11:4] == `KEY_INS) ? `KEY_SPACE : et[i][11:4]);
      end
      key(et[i][14:12], et[i][11:4], 1'b0);
    end
    wb(1'b1, `OFF_CTRL, 32'h05);
    key(`MOD_CTRL, `KEY_ENTER, 1'b1);
    chk("ctrl_enter", edit_o.op, rls_pkg::ED_SAVE);
    key(`MOD_CTRL, `KEY_ENTER, 1'b0);
    wb(1'b1, `OFF_CTRL, 32'h0);
    $display("edit test done");
    report_and_stop();
  end
endmodule : remote_logic_shortcut_io_test
